// ==== verilog/dcdf_pkg.sv ====
// Package of constants and types for the dual clock deep FIFO with flags
package dcdf_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int DATA_W = 18;
    localparam int DEPTH_LOG2_DEF = 13;
    localparam int OFF_W = 16;
    localparam int APB_AW = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] ADDR_AE_OFF = 8'h04;
    localparam logic [APB_AW-1:0] ADDR_AF_OFF = 8'h08;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h0c;
    localparam logic [APB_AW-1:0] ADDR_LEVEL = 8'h10;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_CHAIN_BIT = 0;
    localparam int STATUS_WTOK_BIT = 5;
    localparam int STATUS_RTOK_BIT = 6;
    localparam logic CTRL_CHAIN_RST = 1'b0;
    localparam logic [OFF_W-1:0] AE_OFF_RST = 16'h0040;
    localparam logic [OFF_W-1:0] AF_OFF_RST = 16'h0040;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic full_n;
        logic almost_full_n;
        logic half_full_n;
        logic almost_empty_n;
        logic empty_n;
    } dcdf_flags_t;

    localparam dcdf_flags_t FLAGS_RST = '{full_n: 1'b1, almost_full_n: 1'b1,
        half_full_n: 1'b1, almost_empty_n: 1'b0, empty_n: 1'b0};

    typedef enum logic [1:0] {
        DCDF_TOK_WAIT,
        DCDF_TOK_OWN,
        DCDF_TOK_PASS
    } dcdf_tok_t;

endpackage

// ==== verilog/dcdf_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dcdf_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] stab_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= RST;
            stab_q <= RST;
        end else begin
            meta_q <= din;
            stab_q <= meta_q;
        end
    end

    assign dout = stab_q;
endmodule

// ==== verilog/dcdf_top.sv ====
// Dual clock deep FIFO with fill flags, chain tokens and APB offsets
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module dcdf_top import dcdf_pkg::*; #(
    parameter int AW = DEPTH_LOG2_DEF
) (
    // System
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Write port
    input wire logic wclk,
    input wire logic write_en_n,
    input wire logic [DATA_W-1:0] wdata,
    // Read port
    input wire logic rclk,
    input wire logic read_en_n,
    output logic [DATA_W-1:0] rdata,
    // Flags
    output logic empty_flag_n,
    output logic almost_empty_flag_n,
    output logic half_full_flag_n,
    output logic almost_full_flag_n,
    output logic full_flag_n,
    // Chain and straps
    output logic write_chain_token_out,
    output logic read_chain_token_out,
    input wire logic write_chain_token_in,
    input wire logic read_chain_token_in,
    input wire logic chain_head_strap_n,
    input wire logic almost_flag_sync_strap
);
    localparam int PW = AW + 1;
    localparam int DEPTH_N = 1 << AW;
    localparam logic [PW-1:0] DEPTH = {1'b1, {AW{1'b0}}};
    localparam logic [PW-1:0] HALF = {2'b01, {(AW-1){1'b0}}};
    function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // ------------------------------------------------------------
    // Pin sampling and clock edge detection
    // ------------------------------------------------------------
    logic wclk_s, wen_n_s, rclk_s, ren_n_s;
    logic [DATA_W-1:0] wdata_s;
    logic wtok_in_s, rtok_in_s, head_n_s, sync_mode_s;
    logic wclk_prev_q, rclk_prev_q;
    logic wr_tick, rd_tick;

    // Data and enable share the clock's delay so they stay aligned to its edge
    dcdf_sync #(.W(DATA_W + 2), .RST({1'b0, 1'b1, {DATA_W{1'b0}}})) u_wsync (
        .pclk(pclk),
        .presetn(presetn),
        .din({wclk, write_en_n, wdata}),
        .dout({wclk_s, wen_n_s, wdata_s})
    );
    dcdf_sync #(.W(2), .RST(2'b01)) u_rsync (
        .pclk(pclk),
        .presetn(presetn),
        .din({rclk, read_en_n}),
        .dout({rclk_s, ren_n_s})
    );
    dcdf_sync #(.W(4), .RST(4'b1110)) u_msync (
        .pclk(pclk),
        .presetn(presetn),
        .din({write_chain_token_in, read_chain_token_in, chain_head_strap_n,
              almost_flag_sync_strap}),
        .dout({wtok_in_s, rtok_in_s, head_n_s, sync_mode_s})
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wclk_prev_q <= 1'b0;
            rclk_prev_q <= 1'b0;
        end else begin
            wclk_prev_q <= wclk_s;
            rclk_prev_q <= rclk_s;
        end
    end
    assign wr_tick = wclk_s & ~wclk_prev_q;
    assign rd_tick = rclk_s & ~rclk_prev_q;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic chain_q, chain_d;
    logic [OFF_W-1:0] ae_off_q, ae_off_d, af_off_q, af_off_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;

    // ------------------------------------------------------------
    // FIFO state
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem_q [DEPTH_N];
    logic [PW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic [PW-1:0] wgray_q, wgray_d, rgray_q, rgray_d;
    logic [PW-1:0] wg_r1_q, wg_r2_q, rg_w1_q, rg_w2_q;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    dcdf_flags_t flags_q, flags_d;
    dcdf_tok_t wtok_q, wtok_d, rtok_q, rtok_d;
    logic [1:0] init_q, init_d;
    logic wtok_out_q, wtok_out_d, rtok_out_q, rtok_out_d;
    logic wr_go, rd_go;
    logic [PW-1:0] rbin_w, wbin_r, lvl_w, lvl_r, lvl_true;
    assign rbin_w = g2b(rg_w2_q);
    assign wbin_r = g2b(wg_r2_q);
    assign lvl_true = wptr_q - rptr_q;
    // Writes: enabled, not full, and holding the write token when chained
    assign wr_go = wr_tick & ~wen_n_s & flags_q.full_n
                 & (~chain_q | (wtok_q == DCDF_TOK_OWN));
    assign rd_go = rd_tick & ~ren_n_s & flags_q.empty_n
                 & (~chain_q | (rtok_q == DCDF_TOK_OWN));
    always_comb begin
        wptr_d = wptr_q + PW'(wr_go);
        rptr_d = rptr_q + PW'(rd_go);
        wgray_d = wptr_d ^ (wptr_d >> 1);
        rgray_d = rptr_d ^ (rptr_d >> 1);
        lvl_w = wptr_d - rbin_w;
        lvl_r = wbin_r - rptr_d;
        rdata_d = rd_go ? mem_q[rptr_q[AW-1:0]] : rdata_q;
        flags_d = flags_q;
        if (wr_tick) begin
            flags_d.full_n = ~(lvl_w == DEPTH);
        end
        if (rd_tick) begin
            flags_d.empty_n = ~(lvl_r == '0);
        end
        // Strap high: almost flags track the true level every cycle
        if (sync_mode_s) begin
            flags_d.almost_empty_n = ~(32'(lvl_true) <= 32'(ae_off_q));
            flags_d.almost_full_n = ~(32'(lvl_true) + 32'(af_off_q)
                                    >= 32'(DEPTH));
        end else begin
            if (rd_tick) begin
                flags_d.almost_empty_n = ~(32'(lvl_r) <= 32'(ae_off_q));
            end
            if (wr_tick) begin
                flags_d.almost_full_n = ~(32'(lvl_w) + 32'(af_off_q)
                                        >= 32'(DEPTH));
            end
        end
        flags_d.half_full_n = ~(lvl_true > HALF);
    end

    always_ff @(posedge pclk) begin
        if (wr_go) begin
            mem_q[wptr_q[AW-1:0]] <= wdata_s;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_q <= '0;
            rptr_q <= '0;
            wgray_q <= '0;
            rgray_q <= '0;
            wg_r1_q <= '0;
            wg_r2_q <= '0;
            rg_w1_q <= '0;
            rg_w2_q <= '0;
            rdata_q <= '0;
            flags_q <= FLAGS_RST;
        end else begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            wgray_q <= wgray_d;
            rgray_q <= rgray_d;
            wg_r1_q <= wgray_q;
            wg_r2_q <= wg_r1_q;
            rg_w1_q <= rgray_q;
            rg_w2_q <= rg_w1_q;
            rdata_q <= rdata_d;
            flags_q <= flags_d;
        end
    end

    // ------------------------------------------------------------
    // Chain tokens
    // ------------------------------------------------------------
    // Head strap read once, after its synchroniser has filled
    always_comb begin
        init_d = (init_q == 2'd3) ? init_q : init_q + 2'd1;
        wtok_d = wtok_q;
        rtok_d = rtok_q;
        if (init_q == 2'd2) begin
            wtok_d = head_n_s ? DCDF_TOK_WAIT : DCDF_TOK_OWN;
            rtok_d = head_n_s ? DCDF_TOK_WAIT : DCDF_TOK_OWN;
        end else if (init_q == 2'd3) begin
            if (wr_tick) begin
                case (wtok_q)
                    DCDF_TOK_OWN: if (wr_go && lvl_w == DEPTH) wtok_d = DCDF_TOK_PASS;
                    DCDF_TOK_PASS: wtok_d = DCDF_TOK_WAIT;
                    DCDF_TOK_WAIT: if (!wtok_in_s) wtok_d = DCDF_TOK_OWN;
                    default: wtok_d = DCDF_TOK_WAIT;
                endcase
            end
            if (rd_tick) begin
                case (rtok_q)
                    DCDF_TOK_OWN: begin
                        if (rd_go && lvl_r == '0 && wtok_q != DCDF_TOK_OWN) begin
                            rtok_d = DCDF_TOK_PASS;
                        end
                    end
                    DCDF_TOK_PASS: rtok_d = DCDF_TOK_WAIT;
                    DCDF_TOK_WAIT: if (!rtok_in_s) rtok_d = DCDF_TOK_OWN;
                    default: rtok_d = DCDF_TOK_WAIT;
                endcase
            end
        end
        // Shared pin: half full alone, write token when chained
        wtok_out_d = chain_q ? (wtok_d != DCDF_TOK_PASS) : flags_d.half_full_n;
        rtok_out_d = ~(chain_q && rtok_d == DCDF_TOK_PASS);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_q <= 2'd0;
            wtok_q <= DCDF_TOK_WAIT;
            rtok_q <= DCDF_TOK_WAIT;
            wtok_out_q <= 1'b1;
            rtok_out_q <= 1'b1;
        end else begin
            init_q <= init_d;
            wtok_q <= wtok_d;
            rtok_q <= rtok_d;
            wtok_out_q <= wtok_out_d;
            rtok_out_q <= rtok_out_d;
        end
    end

    // ------------------------------------------------------------
    // APB slave, one wait-free access phase
    // ------------------------------------------------------------
    always_comb begin
        chain_d = chain_q;
        ae_off_d = ae_off_q;
        af_off_d = af_off_q;
        prdata_d = prdata_q;
        pready_d = psel & ~penable;
        pslverr_d = 1'b0;
        if (psel && !penable) begin
            prdata_d = '0;
            case (paddr)
                ADDR_CTRL: prdata_d[CTRL_CHAIN_BIT] = chain_q;
                ADDR_AE_OFF: prdata_d[OFF_W-1:0] = ae_off_q;
                ADDR_AF_OFF: prdata_d[OFF_W-1:0] = af_off_q;
                ADDR_STATUS: begin
                    prdata_d[4:0] = flags_q;
                    prdata_d[STATUS_WTOK_BIT] = (wtok_q == DCDF_TOK_OWN);
                    prdata_d[STATUS_RTOK_BIT] = (rtok_q == DCDF_TOK_OWN);
                end
                ADDR_LEVEL: prdata_d[PW-1:0] = lvl_true;
                default: pslverr_d = 1'b1;
            endcase
        end
        if (psel && penable && pready_q && pwrite) begin
            case (paddr)
                ADDR_CTRL: chain_d = pwdata[CTRL_CHAIN_BIT];
                ADDR_AE_OFF: ae_off_d = pwdata[OFF_W-1:0];
                ADDR_AF_OFF: af_off_d = pwdata[OFF_W-1:0];
                default: chain_d = chain_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain_q <= CTRL_CHAIN_RST;
            ae_off_q <= AE_OFF_RST;
            af_off_q <= AF_OFF_RST;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            chain_q <= chain_d;
            ae_off_q <= ae_off_d;
            af_off_q <= af_off_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rdata = rdata_q;
    assign empty_flag_n = flags_q.empty_n;
    assign almost_empty_flag_n = flags_q.almost_empty_n;
    assign half_full_flag_n = flags_q.half_full_n;
    assign almost_full_flag_n = flags_q.almost_full_n;
    assign full_flag_n = flags_q.full_n;
    assign write_chain_token_out = wtok_out_q;
    assign read_chain_token_out = rtok_out_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    empty_edge_only_a: assert property (!rd_tick |=> $stable(flags_q.empty_n))
        else $error("empty flag moved without a read edge");
    full_edge_only_a: assert property (!wr_tick |=> $stable(flags_q.full_n))
        else $error("full flag moved without a write edge");
    write_blocked_a: assert property (wr_tick && !flags_q.full_n |=> $stable(wptr_q))
        else $error("write taken while full");
    read_blocked_a: assert property (
        rd_tick && !flags_q.empty_n |=> $stable(rptr_q) && $stable(rdata_q))
        else $error("read taken while empty");
    empty_set_a: assert property (rd_tick && wbin_r == rptr_d |=> !empty_flag_n)
        else $error("empty flag not low with no words");
    full_set_a: assert property (wr_tick && lvl_w == DEPTH |=> !full_flag_n)
        else $error("full flag not low at capacity");
    write_stream_a: assert property (wr_go |=> wptr_q == $past(wptr_q) + PW'(1))
        else $error("back to back write lost");
    read_word_a: assert property (
        rd_go |=> rdata_q == mem_q[$past(rptr_q[AW-1:0])] && rptr_q == $past(rptr_q) + PW'(1))
        else $error("read did not deliver next word");
    almost_sync_a: assert property (
        !sync_mode_s && !rd_tick ##1 !sync_mode_s |-> $stable(flags_q.almost_empty_n))
        else $error("synchronous almost empty moved off read edge");
    half_pin_a: assert property (
        !chain_q && !$past(chain_q) |-> write_chain_token_out == $past(flags_d.half_full_n))
        else $error("shared pin does not follow half full");
endmodule

// ==== test/dcdf_partner.sv ====
// Producer and consumer model for the FIFO write and read pins
`timescale 1ns/1ps
module dcdf_partner import dcdf_pkg::*; (
    // Clocks
    input wire logic pclk,
    input wire logic wclk,
    input wire logic rclk,
    // Device side
    input wire logic full_flag_n,
    input wire logic empty_flag_n,
    input wire logic [DATA_W-1:0] rdata,
    output logic write_en_n,
    output logic [DATA_W-1:0] wdata,
    output logic read_en_n
);
    logic wq = 1'b0;
    logic rq = 1'b0;
    initial begin
        write_en_n = 1'b1;
        read_en_n = 1'b1;
        wdata = '0;
    end
    always @(posedge pclk) begin
        wq <= wclk;
        rq <= rclk;
    end
    task automatic edge_at(input bit rd, input logic lvl);
        do @(posedge pclk);
        while (!(rd ? (rclk === lvl && rq === !lvl) : (wclk === lvl && wq === !lvl)));
    endtask
    // Launch on the falling edge, so the word holds half a period past the rise
    task automatic put(input logic [DATA_W-1:0] d, output logic acc);
        if (write_en_n)
            edge_at(1'b0, 1'b0);
        write_en_n <= 1'b0;
        wdata <= d;
        edge_at(1'b0, 1'b1);
        acc = full_flag_n;
        edge_at(1'b0, 1'b0);
    endtask
    // Released data is inverted so a stale word never looks valid
    task automatic w_idle();
        write_en_n <= 1'b1;
        wdata <= ~wdata;
        @(posedge pclk);
    endtask
    task automatic get(output logic [DATA_W-1:0] d, output logic acc);
        if (read_en_n)
            edge_at(1'b1, 1'b0);
        read_en_n <= 1'b0;
        edge_at(1'b1, 1'b1);
        acc = empty_flag_n;
        edge_at(1'b1, 1'b0);
        d = rdata;
    endtask
    task automatic r_idle();
        read_en_n <= 1'b1;
        @(posedge pclk);
    endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the dual clock FIFO with flags
`timescale 1ns/1ps
module testbench import dcdf_pkg::*;;
    localparam int DEPTH = 16;
    localparam int AE = 2;
    localparam int AF = 3;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, wclk = 1'b0, rclk_free = 1'b0, tie_clk = 1'b0;
    logic write_en_n, read_en_n, ring = 1'b0, head_n = 1'b0, strap = 1'b0;
    logic [DATA_W-1:0] wdata, rdata;
    logic wtok_out, rtok_out;
    wire logic e_n, ae_n, hf_n, af_n, f_n;
    wire dcdf_flags_t flg = {f_n, af_n, hf_n, ae_n, e_n};
    wire logic rclk = tie_clk ? wclk : rclk_free;
    wire logic wtok_in = ring ? wtok_out : 1'b0;
    wire logic rtok_in = ring ? rtok_out : 1'b0;
    int mismatches = 0, samples_checked = 0, cyc = 0, wtok_low = 0, rtok_low = 0;
    int q[$];

    always #2.5 pclk = ~pclk;
    initial #3.1 forever #80 wclk = ~wclk;
    initial #41.7 forever #80 rclk_free = ~rclk_free;

    dcdf_top #(.AW(4)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wclk(wclk), .write_en_n(write_en_n),
        .wdata(wdata), .rclk(rclk), .read_en_n(read_en_n), .rdata(rdata),
        .empty_flag_n(e_n), .almost_empty_flag_n(ae_n), .half_full_flag_n(hf_n),
        .almost_full_flag_n(af_n), .full_flag_n(f_n), .write_chain_token_out(wtok_out),
        .read_chain_token_out(rtok_out), .write_chain_token_in(wtok_in),
        .read_chain_token_in(rtok_in), .chain_head_strap_n(head_n),
        .almost_flag_sync_strap(strap));
    dcdf_partner far (.pclk(pclk), .wclk(wclk), .rclk(rclk), .full_flag_n(f_n),
        .empty_flag_n(e_n), .rdata(rdata), .write_en_n(write_en_n), .wdata(wdata),
        .read_en_n(read_en_n));

    // --------
    // Tasks
    // --------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flags(input dcdf_flags_t got, input dcdf_flags_t exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t flags %b expected %b", $time, got, exp);
        end
    endtask
    function automatic dcdf_flags_t exp_fl(input int n);
        return '{full_n: n != DEPTH, almost_full_n: n < DEPTH - AF,
            half_full_n: n <= DEPTH / 2, almost_empty_n: n > AE, empty_n: n != 0};
    endfunction
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask
    // Long enough for both clocks to tick a few times after any change
    task automatic settle_check(input int n);
        logic [31:0] r;
        logic e;
        repeat (100) @(posedge pclk);
        cmp_flags(flg, exp_fl(n));
        apb(1'b0, ADDR_LEVEL, '0, r, e);
        cmp_val(r, 32'(n));
        apb(1'b0, ADDR_STATUS, '0, r, e);
        cmp_flags(r[4:0], exp_fl(n));
        if (!ring)
            cmp_val(32'(wtok_out), 32'(exp_fl(n).half_full_n));
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (ring && presetn && !wtok_out)
            wtok_low <= wtok_low + 1;
        if (ring && presetn && !rtok_out)
            rtok_low <= rtok_low + 1;
        if (cyc == 50000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // --------
    // Main sequence
    // --------
    initial begin
        logic [31:0] r;
        logic e;
        logic acc;
        logic [DATA_W-1:0] d, last;
        void'($urandom(21));
        do_reset();
        cmp_flags(flg, exp_fl(0));
        cmp_val(32'({wtok_out, rtok_out}), 32'h3);
        apb(1'b0, ADDR_AE_OFF, '0, r, e);
        cmp_val(r, 32'h40);
        apb(1'b0, ADDR_AF_OFF, '0, r, e);
        cmp_val(r, 32'h40);
        apb(1'b0, 8'h20, '0, r, e);
        cmp_val({r[30:0], e}, 32'h1);
        apb(1'b1, ADDR_AE_OFF, 32'(AE), r, e);
        apb(1'b1, ADDR_AF_OFF, 32'(AF), r, e);
        apb(1'b1, ADDR_STATUS, 32'hffff_ffff, r, e);
        settle_check(0);
        for (int s = 0; s < 2; s++) begin
            strap <= s[0];
            for (int n = 1; n <= DEPTH + 1; n++) begin
                d = 18'($urandom);
                far.put(d, acc);
                far.w_idle();
                cmp_val(32'(acc), 32'(n <= DEPTH));
                if (acc)
                    q.push_back(d);
                settle_check(q.size());
            end
            for (int n = DEPTH - 1; n >= -1; n--) begin
                far.get(d, acc);
                far.r_idle();
                cmp_val(32'(acc), 32'(n >= 0));
                if (acc)
                    cmp_val(32'(d), 32'(q.pop_front()));
                else
                    cmp_val(32'(d), 32'(last));
                last = d;
                settle_check(q.size());
            end
        end
        for (int t = 0; t < 2; t++) begin
            tie_clk <= t[0];
            fork
                begin
                    logic [DATA_W-1:0] wd;
                    logic wa;
                    for (int k = 0; k < 40; k += wa) begin
                        wd = 18'($urandom);
                        far.put(wd, wa);
                        if (wa)
                            q.push_back(wd);
                        if ($urandom % 4 == 0)
                            far.w_idle();
                    end
                    far.w_idle();
                end
                begin
                    logic [DATA_W-1:0] rd;
                    logic ra;
                    for (int k = 0; k < 40; k += ra) begin
                        far.get(rd, ra);
                        if (ra)
                            cmp_val(32'(rd), 32'(q.pop_front()));
                        if ($urandom % 3 == 0)
                            far.r_idle();
                    end
                    far.r_idle();
                end
            join
            settle_check(q.size());
        end
        tie_clk <= 1'b0;
        ring <= 1'b1;
        head_n <= 1'b0;
        do_reset();
        apb(1'b1, ADDR_CTRL, 32'h1, r, e);
        apb(1'b0, ADDR_STATUS, '0, r, e);
        cmp_val(32'(r[6:5]), 32'h3);
        for (int n = 1; n <= DEPTH; n++) begin
            d = 18'($urandom);
            far.put(d, acc);
            q.push_back(d);
            if (n > DEPTH / 2 && n < DEPTH)
                cmp_val(32'(wtok_out), 32'h1);
        end
        far.w_idle();
        repeat (100) @(posedge pclk);
        cmp_val(32'(wtok_low != 0), 32'h1);
        apb(1'b0, ADDR_STATUS, '0, r, e);
        cmp_val(32'(r[6:5]), 32'h2);
        for (int n = 1; n <= DEPTH; n++) begin
            far.get(d, acc);
            cmp_val(32'(d), 32'(q.pop_front()));
        end
        far.r_idle();
        repeat (100) @(posedge pclk);
        cmp_val(32'(rtok_low != 0), 32'h1);
        report_and_stop();
    end
endmodule
